// ### rtl/tdmsp_core.sv
// TDM multichannel serial port: Wishbone slave, slot engine, key compare
`timescale 1ns/100ps
module tdmsp_core
    import tdmsp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        serial_clk_pin,
    input  wire logic        rx_frame_sync_in,
    input  wire logic        serial_data_in,
    output logic             serial_data_out_pin,
    output logic             serial_data_out_oe_n,
    output logic             tx_frame_sync_valid,
    output logic             rx_frame_sync_out,
    output logic             rx_frame_sync_oe_n,
    output logic             rx_dma_req,
    output logic             rx_irq,
    output logic             compand_law,
    output logic             compand_tx_active,
    output logic             compand_rx_active
);
    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    tdmsp_tx_cfg_t tx_cfg_reg;
    tdmsp_rx_cfg_t rx_cfg_reg;
    logic [31:0] tx_slot_enable_mask_reg;
    logic [31:0] rx_slot_enable_mask_reg;
    logic [31:0] tx_slot_compand_mask_reg;
    logic [31:0] rx_slot_compand_mask_reg;
    logic [31:0] receive_key_pattern_reg;
    logic [31:0] receive_key_mask_reg;
    logic [31:0] tx_buf_reg;
    logic        tx_full_reg;
    logic [31:0] rx_buf_reg;
    logic        rx_full_reg;
    logic        rx_ovf_reg;
    logic [4:0]  slot_reg;
    logic [2:0]  en_pipe_reg;
    logic        active_reg;
    logic        fs_active_reg;
    tdmsp_wb_req_t req;
    logic        wr_hit;
    logic        rd_rx;
    logic        tx_load;
    logic        rx_accept;
    logic [31:0] rx_word;
    logic        tdm_req;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                   adr: wb_adr_i, dat: wb_dat_i};
    assign wr_hit = req.cyc && req.stb && req.we && !wb_ack_o;
    assign rd_rx = req.cyc && req.stb && !req.we && !wb_ack_o
                   && req.adr == TDMSP_RX_DATA_OFS;

    // Byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // ---------------------------------------------------------------
    // Wishbone slave: one registered ack after one wait state, unmapped reads return zero
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else if (ce) begin
            wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
        end
    end

    // Configuration writes; masks map bit n to slot n
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_cfg_reg               <= '0;
            rx_cfg_reg               <= '0;
            tx_slot_enable_mask_reg  <= TDMSP_REG_RESET;
            rx_slot_enable_mask_reg  <= TDMSP_REG_RESET;
            tx_slot_compand_mask_reg <= TDMSP_REG_RESET;
            rx_slot_compand_mask_reg <= TDMSP_REG_RESET;
            receive_key_pattern_reg  <= TDMSP_REG_RESET;
            receive_key_mask_reg     <= TDMSP_REG_RESET;
        end else if (ce && wr_hit) begin
            unique case (req.adr)
                TDMSP_TX_CTRL_OFS: begin
                    tx_cfg_reg.enable      <= req.dat[TDMSP_TXC_ENABLE];
                    tx_cfg_reg.opstyle     <= req.dat[TDMSP_TXC_OPSTYLE];
                    tx_cfg_reg.tdm_en      <= req.dat[TDMSP_TXC_TDM_EN];
                    tx_cfg_reg.sync_src    <= req.dat[TDMSP_TXC_SYNC_SRC];
                    tx_cfg_reg.frame_delay <= req.dat[TDMSP_TXC_FDLY_LO +: 4];
                    tx_cfg_reg.law         <= req.dat[TDMSP_TXC_LAW];
                end
                TDMSP_RX_CTRL_OFS: begin
                    rx_cfg_reg.slot_count <= req.dat[TDMSP_RXC_NSLOT_LO +: 5];
                    rx_cfg_reg.cmp_en     <= req.dat[TDMSP_RXC_CMP_EN];
                    rx_cfg_reg.cmp_pol    <= req.dat[TDMSP_RXC_CMP_POL];
                    rx_cfg_reg.dma_en     <= req.dat[TDMSP_RXC_DMA_EN];
                    rx_cfg_reg.int_fs     <= req.dat[TDMSP_RXC_INT_FS];
                end
                TDMSP_TX_SLOT_EN_OFS: tx_slot_enable_mask_reg <=
                    merge(tx_slot_enable_mask_reg, req.dat, req.sel);
                TDMSP_RX_SLOT_EN_OFS: rx_slot_enable_mask_reg <=
                    merge(rx_slot_enable_mask_reg, req.dat, req.sel);
                TDMSP_TX_CMP_MASK_OFS: tx_slot_compand_mask_reg <=
                    merge(tx_slot_compand_mask_reg, req.dat, req.sel);
                TDMSP_RX_CMP_MASK_OFS: rx_slot_compand_mask_reg <=
                    merge(rx_slot_compand_mask_reg, req.dat, req.sel);
                TDMSP_KEY_PAT_OFS: receive_key_pattern_reg <=
                    merge(receive_key_pattern_reg, req.dat, req.sel);
                TDMSP_KEY_MASK_OFS: receive_key_mask_reg <=
                    merge(receive_key_mask_reg, req.dat, req.sel);
                default: ;
            endcase
        end
    end

    // Read mux, registered with the ack
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else if (ce) begin
            unique case (req.adr)
                TDMSP_TX_CTRL_OFS: wb_dat_o <= {18'h0, tx_cfg_reg.law, slot_reg,
                                                tx_cfg_reg.frame_delay, tx_cfg_reg.sync_src,
                                                tx_cfg_reg.tdm_en, tx_cfg_reg.opstyle,
                                                tx_cfg_reg.enable};
                TDMSP_RX_CTRL_OFS: wb_dat_o <= {23'h0, rx_cfg_reg.int_fs, rx_cfg_reg.dma_en,
                                                rx_cfg_reg.cmp_pol, rx_cfg_reg.cmp_en,
                                                rx_cfg_reg.slot_count};
                TDMSP_TX_SLOT_EN_OFS:  wb_dat_o <= tx_slot_enable_mask_reg;
                TDMSP_RX_SLOT_EN_OFS:  wb_dat_o <= rx_slot_enable_mask_reg;
                TDMSP_TX_CMP_MASK_OFS: wb_dat_o <= tx_slot_compand_mask_reg;
                TDMSP_RX_CMP_MASK_OFS: wb_dat_o <= rx_slot_compand_mask_reg;
                TDMSP_KEY_PAT_OFS:     wb_dat_o <= receive_key_pattern_reg;
                TDMSP_KEY_MASK_OFS:    wb_dat_o <= receive_key_mask_reg;
                TDMSP_TX_DATA_OFS:     wb_dat_o <= tx_buf_reg;
                TDMSP_RX_DATA_OFS:     wb_dat_o <= rx_buf_reg;
                TDMSP_STATUS_OFS:      wb_dat_o <= {28'h0, active_reg, rx_ovf_reg,
                                                    rx_full_reg, tx_full_reg};
                default:               wb_dat_o <= '0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Enable pipeline: style must be non-I2S, one bit for both ways
    // ---------------------------------------------------------------
    assign tdm_req = tx_cfg_reg.enable && tx_cfg_reg.tdm_en && !tx_cfg_reg.opstyle;

    always_ff @(posedge clk) begin
        if (rst) begin
            en_pipe_reg   <= '0;
            active_reg    <= 1'b0;
            fs_active_reg <= 1'b0;
        end else if (ce) begin
            en_pipe_reg   <= {en_pipe_reg[1:0], tdm_req};
            active_reg    <= tdm_req && en_pipe_reg[1];    // 3rd edge
            fs_active_reg <= tdm_req && en_pipe_reg[2];    // 4th edge
        end
    end

    // ---------------------------------------------------------------
    // Pin synchronisers and serial clock edge detect
    // ---------------------------------------------------------------
    logic [1:0] sclk_sync_reg;
    logic [1:0] fs_sync_reg;
    logic [1:0] din_sync_reg;
    logic       sclk_prev_reg;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       own_sclk_reg;
    logic       own_fs_reg;
    logic [3:0] div_reg;
    logic       sclk_now;
    logic       fs_now;

    // Own sync source drives the receive sync pin only; it does not feed back to the slot engine
    always_ff @(posedge clk) begin
        if (rst) begin
            div_reg      <= '0;
            own_sclk_reg <= 1'b0;
        end else if (ce) begin
            div_reg <= (div_reg == TDMSP_FS_RATE_DIV) ? 4'h0 : div_reg + 4'h1;
            if (div_reg == TDMSP_FS_RATE_DIV) begin
                own_sclk_reg <= !own_sclk_reg;
            end
        end
    end

    // Own sync pulse once per 32-bit slot times slot count plus one, after enable
    logic [9:0] own_cnt_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            own_cnt_reg       <= '0;
            own_fs_reg        <= 1'b0;
            rx_frame_sync_out <= 1'b0;
            rx_frame_sync_oe_n <= 1'b1;
        end else if (ce) begin
            rx_frame_sync_oe_n <= !(fs_active_reg && rx_cfg_reg.int_fs);
            if (!(fs_active_reg && rx_cfg_reg.int_fs)) begin
                own_cnt_reg <= '0;
                own_fs_reg  <= 1'b0;
            end else if (div_reg == TDMSP_FS_RATE_DIV && own_sclk_reg) begin
                own_fs_reg  <= (own_cnt_reg == 10'h0);
                own_cnt_reg <= (own_cnt_reg == {rx_cfg_reg.slot_count, 5'h1f})
                               ? 10'h0 : own_cnt_reg + 10'h1;
            end
            rx_frame_sync_out <= own_fs_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_sync_reg <= '0;
            fs_sync_reg   <= '0;
            din_sync_reg  <= '0;
            sclk_prev_reg <= 1'b0;
        end else if (ce) begin
            sclk_sync_reg <= {sclk_sync_reg[0], serial_clk_pin};
            fs_sync_reg   <= {fs_sync_reg[0], rx_frame_sync_in};
            din_sync_reg  <= {din_sync_reg[0], serial_data_in};
            sclk_prev_reg <= sclk_sync_reg[1];
        end
    end
    assign sclk_now  = sclk_sync_reg[1];
    assign fs_now    = fs_sync_reg[1];
    assign sclk_rise = sclk_now && !sclk_prev_reg;
    assign sclk_fall = !sclk_now && sclk_prev_reg;

    // ---------------------------------------------------------------
    // Slot engine: sync restarts slot 0 at any moment
    // ---------------------------------------------------------------
    tdmsp_state_t state_reg;
    logic [3:0]  dly_reg;
    logic [4:0]  bit_reg;
    logic [31:0] rx_sh_reg;
    logic [31:0] tx_sh_reg;
    logic        tx_slot_on_reg;
    logic        word_done;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= TDMSP_IDLE;
            dly_reg   <= '0;
            bit_reg   <= '0;
            slot_reg  <= '0;
        end else if (ce) begin
            if (!active_reg) begin
                state_reg <= TDMSP_IDLE;
                slot_reg  <= '0;
            end else if (sclk_rise && fs_now) begin
                // Late sync from a back-to-back frame wins over the word in flight
                slot_reg <= '0;
                // With no delay bit 0 is taken on this very edge
                bit_reg  <= (tx_cfg_reg.frame_delay == 4'h0) ? 5'h1 : 5'h0;
                dly_reg  <= tx_cfg_reg.frame_delay;
                state_reg <= (tx_cfg_reg.frame_delay == 4'h0) ? TDMSP_SHIFT
                                                               : TDMSP_DELAY;
            end else if (sclk_rise) begin
                unique case (state_reg)
                    TDMSP_IDLE: ;
                    TDMSP_DELAY: begin
                        dly_reg <= dly_reg - 4'h1;
                        if (dly_reg == 4'h1) begin
                            state_reg <= TDMSP_SHIFT;
                            bit_reg   <= 5'h1;  // Bit 0 lands on this edge
                        end
                    end
                    TDMSP_SHIFT: begin
                        bit_reg <= bit_reg + 5'h1;
                        if (word_done) begin
                            slot_reg <= (slot_reg == rx_cfg_reg.slot_count)
                                        ? 5'h0 : slot_reg + 5'h1;
                        end
                    end
                endcase
            end
        end
    end
    assign word_done = (state_reg == TDMSP_SHIFT) && (bit_reg == TDMSP_WORD_LAST)
                       && sclk_rise && !fs_now;

    // Receive shifter, MSB first, sampled on rising serial clock
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_sh_reg <= '0;
        end else if (ce && active_reg && sclk_rise
                     && (state_reg == TDMSP_SHIFT
                         || (fs_now && tx_cfg_reg.frame_delay == 4'h0)
                         || (state_reg == TDMSP_DELAY && dly_reg == 4'h1))) begin
            rx_sh_reg <= {rx_sh_reg[30:0], din_sync_reg[1]};
        end
    end
    assign rx_word = {rx_sh_reg[30:0], din_sync_reg[1]};

    // Key compare: mask-one bits excluded; compare slots set by tx compand mask
    logic key_hit;
    logic cmp_slot;
    assign key_hit  = ((rx_word ^ receive_key_pattern_reg)
                       & ~receive_key_mask_reg) == '0;
    assign cmp_slot = rx_cfg_reg.cmp_en && tx_slot_compand_mask_reg[slot_reg];
    assign rx_accept = word_done && rx_slot_enable_mask_reg[slot_reg]
                       && (!cmp_slot || (key_hit == rx_cfg_reg.cmp_pol));

    // Receive buffer and request outputs; rejects touch nothing
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_buf_reg  <= '0;
            rx_full_reg <= 1'b0;
            rx_ovf_reg  <= 1'b0;
            rx_dma_req  <= 1'b0;
            rx_irq      <= 1'b0;
        end else if (ce) begin
            rx_dma_req <= rx_accept && rx_cfg_reg.dma_en;
            rx_irq     <= rx_accept && !rx_cfg_reg.dma_en;
            if (rx_accept) begin
                rx_buf_reg  <= rx_word;
                rx_full_reg <= 1'b1;                                            // Set wins
                rx_ovf_reg  <= rx_ovf_reg || rx_full_reg;
            end else if (rd_rx) begin
                rx_full_reg <= 1'b0;
                rx_ovf_reg  <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Transmit buffer written from the bus, shifter changed on falling serial clock
    // ---------------------------------------------------------------
    logic tx_slot_start;
    assign tx_load = wr_hit && req.adr == TDMSP_TX_DATA_OFS;
    assign tx_slot_start = active_reg && sclk_fall && state_reg == TDMSP_SHIFT
                           && bit_reg == 5'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_buf_reg     <= '0;
            tx_full_reg    <= 1'b0;
            tx_sh_reg      <= '0;
            tx_slot_on_reg <= 1'b0;
        end else if (ce) begin
            if (tx_slot_start) begin
                // Enabled slot with no word queued stays undriven
                tx_slot_on_reg <= tx_slot_enable_mask_reg[slot_reg] && tx_full_reg;
                if (tx_slot_enable_mask_reg[slot_reg] && tx_full_reg) begin
                    tx_sh_reg   <= tx_buf_reg;
                    tx_full_reg <= 1'b0;
                end
            end else if (sclk_fall && tx_slot_on_reg) begin
                tx_sh_reg <= {tx_sh_reg[30:0], 1'b0};
            end
            if (!active_reg || state_reg != TDMSP_SHIFT) begin
                tx_slot_on_reg <= 1'b0;
            end
            if (tx_load) begin
                tx_buf_reg  <= merge(tx_buf_reg, req.dat, req.sel);
                tx_full_reg <= 1'b1;
            end
        end
    end

    // Pin drivers: float inactive slots, valid strobe always driven
    always_ff @(posedge clk) begin
        if (rst) begin
            serial_data_out_pin  <= 1'b0;
            serial_data_out_oe_n <= 1'b1;
            tx_frame_sync_valid  <= 1'b0;
            compand_law          <= 1'b0;
            compand_tx_active    <= 1'b0;
            compand_rx_active    <= 1'b0;
        end else if (ce) begin
            serial_data_out_pin  <= tx_sh_reg[31];
            serial_data_out_oe_n <= !tx_slot_on_reg;
            tx_frame_sync_valid  <= tx_slot_on_reg;
            compand_law          <= tx_cfg_reg.law;
            compand_tx_active    <= tx_slot_on_reg && !rx_cfg_reg.cmp_en
                                    && tx_slot_compand_mask_reg[slot_reg];
            compand_rx_active    <= active_reg && !rx_cfg_reg.cmp_en
                                    && rx_slot_enable_mask_reg[slot_reg]
                                    && rx_slot_compand_mask_reg[slot_reg];
        end
    end

    logic unused_ok;
    assign unused_ok = &{1'b0, tx_cfg_reg.sync_src, own_sclk_reg};
endmodule : tdmsp_core

// ### rtl/tdmsp_pkg.sv
// Package: register map, field layout, carriers and timing for the TDM serial port
package tdmsp_pkg;
    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] TDMSP_TX_CTRL_OFS     = 8'h00;
    localparam logic [7:0] TDMSP_RX_CTRL_OFS     = 8'h04;
    localparam logic [7:0] TDMSP_TX_SLOT_EN_OFS  = 8'h08;
    localparam logic [7:0] TDMSP_RX_SLOT_EN_OFS  = 8'h0c;
    localparam logic [7:0] TDMSP_TX_CMP_MASK_OFS = 8'h10;
    localparam logic [7:0] TDMSP_RX_CMP_MASK_OFS = 8'h14;
    localparam logic [7:0] TDMSP_KEY_PAT_OFS     = 8'h18;
    localparam logic [7:0] TDMSP_KEY_MASK_OFS    = 8'h1c;
    localparam logic [7:0] TDMSP_TX_DATA_OFS     = 8'h20;
    localparam logic [7:0] TDMSP_RX_DATA_OFS     = 8'h24;
    localparam logic [7:0] TDMSP_STATUS_OFS      = 8'h28;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    // tx_control_word
    localparam int TDMSP_TXC_ENABLE   = 0;
    localparam int TDMSP_TXC_OPSTYLE  = 1;
    localparam int TDMSP_TXC_TDM_EN   = 2;
    localparam int TDMSP_TXC_SYNC_SRC = 3;
    localparam int TDMSP_TXC_FDLY_LO  = 4;
    localparam int TDMSP_TXC_SLOT_LO  = 8;
    localparam int TDMSP_TXC_LAW      = 13;
    // rx_control_word
    localparam int TDMSP_RXC_NSLOT_LO = 0;
    localparam int TDMSP_RXC_CMP_EN   = 5;
    localparam int TDMSP_RXC_CMP_POL  = 6;
    localparam int TDMSP_RXC_DMA_EN   = 7;
    localparam int TDMSP_RXC_INT_FS   = 8;
    // status
    localparam int TDMSP_ST_TX_FULL   = 0;
    localparam int TDMSP_ST_RX_FULL   = 1;
    localparam int TDMSP_ST_RX_OVF    = 2;
    localparam int TDMSP_ST_ACTIVE    = 3;

    // ---------------------------------------------------------------
    // Sizes, reset values and timing
    // ---------------------------------------------------------------
    localparam int          TDMSP_WORD_BITS   = 32;
    localparam logic [4:0]  TDMSP_WORD_LAST   = 5'h1f;
    localparam logic [31:0] TDMSP_REG_RESET   = 32'h0000_0000;
    localparam int          TDMSP_ACT_DELAY   = 3;  // cycles from enable to slot logic
    localparam int          TDMSP_FS_DELAY    = 4;  // cycles from enable to own syncs
    localparam logic [3:0]  TDMSP_FS_RATE_DIV = 4'h7; // own sync/clock divider end count; half period is 8 cycles

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [4:0] slot_count;
        logic       cmp_en;
        logic       cmp_pol;
        logic       dma_en;
        logic       int_fs;
    } tdmsp_rx_cfg_t;

    typedef struct packed {
        logic       enable;
        logic       opstyle;
        logic       tdm_en;
        logic       sync_src;
        logic [3:0] frame_delay;
        logic       law;
    } tdmsp_tx_cfg_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } tdmsp_wb_req_t;

    typedef enum logic [1:0] {
        TDMSP_IDLE,
        TDMSP_DELAY,
        TDMSP_SHIFT
    } tdmsp_state_t;
endpackage : tdmsp_pkg

// ### verification/tdmsp_checker.sv
// Checker: bus handshake, slot drive and accept pulses
`timescale 1ns/100ps
module tdmsp_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic serial_data_out_oe_n,
    input wire logic tx_frame_sync_valid,
    input wire logic rx_dma_req,
    input wire logic rx_irq
);
    // ----------
    // Properties
    // ----------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_ACK_TAKE: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_VALID_OE: assert property (tx_frame_sync_valid == !serial_data_out_oe_n)
        else $error("valid and drive disagree");
    AST_VALID_HOLD: assert property ($rose(tx_frame_sync_valid) |=> tx_frame_sync_valid[*8])
        else $error("valid dropped inside slot");
    AST_FLOAT_HOLD: assert property ($rose(serial_data_out_oe_n) |=> serial_data_out_oe_n[*8])
        else $error("float ended inside slot");
    AST_IRQ_PULSE: assert property (rx_irq |=> !rx_irq)
        else $error("interrupt pulse too long");
    AST_DMA_PULSE: assert property (rx_dma_req |=> !rx_dma_req)
        else $error("dma pulse too long");
    AST_ONE_PATH: assert property (!(rx_dma_req && rx_irq))
        else $error("dma and interrupt together");
endmodule : tdmsp_checker
bind tdmsp_core tdmsp_checker i_tdmsp_checker (.clk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .serial_data_out_oe_n, .tx_frame_sync_valid, .rx_dma_req, .rx_irq);

// ### verification/tdmsp_peer.sv
// Peer model: one two-slot frame per run pulse, clock still between frames
`timescale 1ns/100ps
module tdmsp_peer (
    input  wire logic        run,
    input  wire logic [31:0] word,
    input  wire logic        dev_data,
    output logic             sclk,
    output logic             fsync,
    output logic             sdata,
    output logic [31:0]      cap
);
    // One clock feeds both directions; sync marks slot 0 bit 0
    initial begin
        sclk = 1'b0;
        fsync = 1'b0;
        sdata = 1'b0;
        cap = 32'h0;
        forever begin
            @(posedge run);
            #5; // Keep link edges clear of the sampling clock edge
            for (int s = 0; s < 64; s++) begin
                sdata = word[31 - (s % 32)];
                fsync = (s == 0);
                #80 sclk = 1'b1;
                cap = {cap[30:0], dev_data};
                #80 sclk = 1'b0;
            end
            fsync = 1'b0;
            sdata = ~sdata; // Released line shows no stale bit
        end
    end
endmodule : tdmsp_peer

// ### verification/tb.sv
// Testbench: I2S lockout, slot select and key compare over frames
`timescale 1ns/100ps
module tb;
    import tdmsp_pkg::*;
    localparam logic [31:0] WORD = 32'ha5c3_0f96;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, q, cap, rdo;
    logic        sclk, fs, sdi, dout, oe_n, ack, dma, irq;
    wire         dpin = oe_n ? 1'bz : dout;
    int error_cnt = 0, num_checks = 0, irq_n = 0, dma_n = 0;
    logic [31:0] kp[3] = '{~WORD, ~WORD, WORD ^ 32'hffff};
    logic [31:0] km[3] = '{32'h0, 32'h0, 32'hffff};
    logic [31:0] rc[3] = '{32'h21, 32'h61, 32'he1};
    int ei[3] = '{1, 0, 0};
    int ed[3] = '{0, 0, 1};
    always #10 clk = ~clk;
    // Count accept pulses
    always @(posedge clk) begin
        irq_n += int'(irq === 1'b1);
        dma_n += int'(dma === 1'b1);
    end
    tdmsp_core i_tdmsp_core (.clk(clk), .rst(rst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdo),
        .wb_ack_o(ack), .serial_clk_pin(sclk), .rx_frame_sync_in(fs), .serial_data_in(sdi),
        .serial_data_out_pin(dout), .serial_data_out_oe_n(oe_n), .tx_frame_sync_valid(),
        .rx_frame_sync_out(), .rx_frame_sync_oe_n(), .rx_dma_req(dma), .rx_irq(irq),
        .compand_law(), .compand_tx_active(), .compand_rx_active());
    tdmsp_peer i_tdmsp_peer (.run(run), .word(WORD), .dev_data(dpin), .sclk(sclk), .fsync(fs),
        .sdata(sdi), .cap(cap));
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Classic cycle; hold until ack, release for one cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdo;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            complete_run();
        end
        @(posedge clk);
    endtask : bus
    // One frame of two slots, then count the accept pulses
    task automatic frame(input int exp_irq, input int exp_dma);
        irq_n = 0;
        dma_n = 0;
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        repeat (560) @(posedge clk);
        chk(irq_n, exp_irq);
        chk(dma_n, exp_dma);
    endtask : frame
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b1, TDMSP_TX_CTRL_OFS, 32'h7);
        bus(1'b0, TDMSP_STATUS_OFS, 32'h0);
        chk(q & 32'h8, 32'h0);
        bus(1'b1, TDMSP_RX_CTRL_OFS, 32'h1);
        bus(1'b1, TDMSP_RX_SLOT_EN_OFS, 32'h2);
        bus(1'b1, TDMSP_TX_SLOT_EN_OFS, 32'h2);
        bus(1'b1, TDMSP_TX_DATA_OFS, WORD);
        bus(1'b1, TDMSP_TX_CTRL_OFS, 32'h5);
        repeat (3) @(posedge clk); // Slot logic wakes three cycles after enable
        bus(1'b0, TDMSP_STATUS_OFS, 32'h0);
        chk(q & 32'h8, 32'h8);
        frame(1, 0);
        chk(cap, WORD);
        bus(1'b0, TDMSP_RX_DATA_OFS, 32'h0);
        chk(q, WORD);
        bus(1'b1, TDMSP_TX_CMP_MASK_OFS, 32'h2);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, TDMSP_KEY_PAT_OFS, kp[i]);
            bus(1'b1, TDMSP_KEY_MASK_OFS, km[i]);
            bus(1'b1, TDMSP_RX_CTRL_OFS, rc[i]);
            frame(ei[i], ed[i]);
        end
        complete_run();
    end
endmodule : tb
